/* File: rtl/mne_map.vh */
// Constants for the multiply / negate / no-operation execution datapath.
// Assumes nothing; definitions only.
`ifndef MNE_MAP_VH
`define MNE_MAP_VH

// Opcode patterns, compared against instruction bits 15:8, 15:9, 15:12 or the whole word
`define MNE_OPC_MUL_LIT 8'h0d
`define MNE_OPC_MUL_REG 7'h01
`define MNE_OPC_NEG_REG 7'h36
`define MNE_OPC_NOP_ALL 16'h0000
`define MNE_OPC_NOP_TOP 4'hf

// Indexed literal offset window top
`define MNE_IDX_LIMIT 8'h5f

// Access bank split: access bank offsets below 0x60 map to bank 0
`define MNE_ACC_SPLIT 8'h60
`define MNE_ACC_HIGH_BANK 4'hf

// Phases of one instruction cycle
`define MNE_PH_DECODE 2'd0
`define MNE_PH_READ 2'd1
`define MNE_PH_PROCESS 2'd2
`define MNE_PH_WRITE 2'd3

// Status flag bit positions
`define MNE_FLAG_C 0
`define MNE_FLAG_DC 1
`define MNE_FLAG_Z 2
`define MNE_FLAG_OV 3
`define MNE_FLAG_N 4

// Reset values
`define MNE_RST_BYTE 8'h00
`define MNE_RST_FLAGS 5'h00

`endif

/* File: rtl/mne_data_ram.v */
// Data memory: 4096 bytes, one write port, registered read data.
// Assumes the caller holds address stable across read and write phases.
`timescale 1ns/1ps
`default_nettype none

module mne_data_ram #(
    parameter AW = 12,
    parameter DW = 8
) (
    // Clock
    input wire clk,
    // Read port
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data,
    // Write port
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // No reset: contents are undefined until written
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // mne_data_ram

`default_nettype wire

/* File: rtl/mne_exec.v */
// Execution datapath for literal multiply, register multiply, negate and
// no-operation. One instruction cycle spans four clock phases.
// Assumes INSTR is held stable while INSTR_VALID is high and taken at decode.
//
// What this block does
// - Literal multiply writes unsigned product pair
// - Register multiply writes product, operands unchanged
// - Multiplies keep flags and accumulator unchanged
// - No zero, carry or overflow on multiply
// - Access bit 0 access bank, 1 bank register
// - Extended set, access, address <=95: indexed
// - Negate writes inverted plus one, sets flags
`timescale 1ns/1ps
`default_nettype none
`include "mne_map.vh"

module mne_exec #(
    parameter AW = 12
) (
    // Clock and reset
    input wire SYS_CLK,
    input wire RESET,
    // Instruction stream
    input wire [15:0] INSTR,
    input wire INSTR_VALID,
    output wire INSTR_READY,
    output reg INSTR_DONE,
    // Core context
    input wire [7:0] ACCUM,
    input wire [3:0] BANK_SELECT_REG,
    input wire [AW-1:0] INDEX_BASE,
    input wire EXT_SET_EN,
    // Results
    output reg [7:0] PRODUCT_HIGH_BYTE,
    output reg [7:0] PRODUCT_LOW_BYTE,
    output reg [4:0] STATUS_FLAGS,
    output reg [2:0] PHASE,
    output reg BAD_OPCODE,
    // Data memory debug port
    input wire [AW-1:0] DBG_ADDR,
    output wire [7:0] DBG_DATA
);
    localparam OP_NOP = 3'd0;
    localparam OP_MUL_LIT = 3'd1;
    localparam OP_MUL_REG = 3'd2;
    localparam OP_NEG = 3'd3;
    localparam OP_BAD = 3'd4;

    reg [1:0] ph_r;
    reg busy_r;
    reg [2:0] op_r;
    reg [7:0] lit_r;
    reg [AW-1:0] addr_r;
    reg [7:0] opnd_r;
    reg [7:0] res_r;
    reg [4:0] flags_nxt_r;
    reg [15:0] prod_r;
    wire [7:0] ram_q;
    reg ram_we;
    reg [2:0] op_dec;
    reg [AW-1:0] addr_dec;

    // Effective address from the 8-bit operand field
    function [AW-1:0] eff_addr;
        input [7:0] f;
        input acc_sel;
        input ext;
        input [3:0] bank;
        input [AW-1:0] base;
        begin
            if (acc_sel)
                eff_addr = {bank, f};
            else if (ext && f <= `MNE_IDX_LIMIT)
                eff_addr = base + {{(AW-8){1'b0}}, f};
            else if (f < `MNE_ACC_SPLIT)
                eff_addr = {4'h0, f};
            else
                eff_addr = {`MNE_ACC_HIGH_BANK, f};
        end
    endfunction

    // Decode; anything outside this block's set is reported, not executed
    always @*
    begin
        op_dec = OP_BAD;
        if (INSTR == `MNE_OPC_NOP_ALL || INSTR[15:12] == `MNE_OPC_NOP_TOP)
            op_dec = OP_NOP;
        else if (INSTR[15:8] == `MNE_OPC_MUL_LIT)
            op_dec = OP_MUL_LIT;
        else if (INSTR[15:9] == `MNE_OPC_MUL_REG)
            op_dec = OP_MUL_REG;
        else if (INSTR[15:9] == `MNE_OPC_NEG_REG)
            op_dec = OP_NEG;
        addr_dec = eff_addr(INSTR[7:0], INSTR[8], EXT_SET_EN,
                            BANK_SELECT_REG, INDEX_BASE);
    end

    assign INSTR_READY = !busy_r;

    always @*
    begin
        ram_we = busy_r && ph_r == `MNE_PH_WRITE && op_r == OP_NEG;
    end

    mne_data_ram #(.AW(AW), .DW(8)) u_ram (
        .clk(SYS_CLK),
        .rd_addr(busy_r ? addr_r : DBG_ADDR),
        .rd_data(ram_q),
        .wr_en(ram_we),
        .wr_addr(addr_r),
        .wr_data(res_r)
    );
    assign DBG_DATA = ram_q;

    // Four-phase sequencer
    always @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            ph_r <= `MNE_PH_DECODE;
            busy_r <= 1'b0;
            op_r <= OP_NOP;
            lit_r <= `MNE_RST_BYTE;
            addr_r <= {AW{1'b0}};
            opnd_r <= `MNE_RST_BYTE;
            res_r <= `MNE_RST_BYTE;
            flags_nxt_r <= `MNE_RST_FLAGS;
            prod_r <= 16'h0000;
            PRODUCT_HIGH_BYTE <= `MNE_RST_BYTE;
            PRODUCT_LOW_BYTE <= `MNE_RST_BYTE;
            STATUS_FLAGS <= `MNE_RST_FLAGS;
            PHASE <= 3'h0;
            BAD_OPCODE <= 1'b0;
            INSTR_DONE <= 1'b0;
        end
        else
        begin
            INSTR_DONE <= 1'b0;
            BAD_OPCODE <= 1'b0;
            PHASE <= {busy_r, ph_r};
            if (!busy_r)
            begin
                if (INSTR_VALID)
                begin
                    busy_r <= 1'b1;
                    ph_r <= `MNE_PH_READ;
                    op_r <= (op_dec == OP_BAD) ? OP_NOP : op_dec;
                    BAD_OPCODE <= (op_dec == OP_BAD);
                    lit_r <= INSTR[7:0];
                    addr_r <= addr_dec;
                end
            end
            else
            begin
                case (ph_r)
                    `MNE_PH_READ:
                    begin
                        // RAM read data appears next phase
                        ph_r <= `MNE_PH_PROCESS;
                    end
                    `MNE_PH_PROCESS:
                    begin
                        ph_r <= `MNE_PH_WRITE;
                        opnd_r <= ram_q;
                        case (op_r)
                            OP_MUL_LIT:
                                prod_r <= ACCUM * lit_r;
                            OP_MUL_REG:
                                prod_r <= ACCUM * ram_q;
                            OP_NEG:
                            begin
                                res_r <= ~ram_q + 8'h01;
                                flags_nxt_r <= neg_flags(ram_q);
                            end
                            default:
                                res_r <= res_r;
                        endcase
                    end
                    `MNE_PH_WRITE:
                    begin
                        ph_r <= `MNE_PH_DECODE;
                        busy_r <= 1'b0;
                        INSTR_DONE <= 1'b1;
                        if (op_r == OP_MUL_LIT || op_r == OP_MUL_REG)
                        begin
                            // Flags untouched on multiply
                            PRODUCT_HIGH_BYTE <= prod_r[15:8];
                            PRODUCT_LOW_BYTE <= prod_r[7:0];
                        end
                        if (op_r == OP_NEG)
                            STATUS_FLAGS <= flags_nxt_r;
                    end
                    default:
                        ph_r <= `MNE_PH_DECODE;
                endcase
            end
        end
    end

    // Flags of 0 - x as computed by ~x + 1
    function [4:0] neg_flags;
        input [7:0] x;
        reg [8:0] s;
        reg [4:0] h;
        reg [7:0] r;
        begin
            s = {1'b0, ~x} + 9'h001;
            h = {1'b0, ~x[3:0]} + 5'h01;
            r = s[7:0];
            neg_flags = 5'h00;
            neg_flags[`MNE_FLAG_C] = s[8];
            neg_flags[`MNE_FLAG_DC] = h[4];
            neg_flags[`MNE_FLAG_Z] = (r == 8'h00);
            neg_flags[`MNE_FLAG_OV] = (x == 8'h80);
            neg_flags[`MNE_FLAG_N] = r[7];
        end
    endfunction
endmodule // mne_exec

`default_nettype wire

/* File: bench/mne_exec_assertions.sv */
// Port checker for the execution datapath.
// Bound to mne_exec; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module mne_chk (
    // Clock
    input wire SYS_CLK,
    input wire RESET,
    // Request
    input wire [15:0] INSTR,
    input wire INSTR_VALID,
    input wire INSTR_READY,
    input wire [7:0] ACCUM,
    // Result
    input wire INSTR_DONE,
    input wire [7:0] PRODUCT_HIGH_BYTE,
    input wire [7:0] PRODUCT_LOW_BYTE,
    input wire [4:0] STATUS_FLAGS
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    wire tk = INSTR_READY && INSTR_VALID;
    wire [7:0] op = INSTR[15:8];
    wire [20:0] st = {PRODUCT_HIGH_BYTE, PRODUCT_LOW_BYTE, STATUS_FLAGS};
    property p_done; tk |-> ##4 INSTR_DONE; endproperty
    a_done: assert property (p_done) else $error("late done");
    property p_busy; tk |=> !INSTR_READY [*3] ##1 INSTR_READY; endproperty
    a_busy: assert property (p_busy) else $error("busy span");
    property p_pulse; INSTR_DONE |=> !INSTR_DONE; endproperty
    a_pulse: assert property (p_pulse) else $error("long done");
    property p_lit; tk && op == 8'h0d |-> ##4
        st[20:5] == $past(ACCUM, 4) * $past(INSTR[7:0], 4); endproperty
    a_lit: assert property (p_lit) else $error("bad product");
    property p_keep; tk && (op == 8'h0d || op[7:1] == 7'h01) |->
        ##2 $stable(STATUS_FLAGS) [*3]; endproperty
    a_keep: assert property (p_keep) else $error("flags moved");
    property p_nop; tk && (INSTR == 16'h0 || op[7:4] == 4'hf) |->
        ##2 $stable(st) [*3]; endproperty
    a_nop: assert property (p_nop) else $error("no-op moved");
    property p_neg; tk && op[7:1] == 7'h36 |-> ##4 STATUS_FLAGS[0] ==
        STATUS_FLAGS[2] && (STATUS_FLAGS[4] || !STATUS_FLAGS[3]); endproperty
    a_neg: assert property (p_neg) else $error("negate flags");
    property p_hold; !INSTR_DONE |-> $stable(st); endproperty
    a_hold: assert property (p_hold) else $error("result moved");
endmodule // mne_chk
bind mne_exec mne_chk i_mne_chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .INSTR(INSTR), .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY),
    .ACCUM(ACCUM), .INSTR_DONE(INSTR_DONE), .STATUS_FLAGS(STATUS_FLAGS),
    .PRODUCT_HIGH_BYTE(PRODUCT_HIGH_BYTE),
    .PRODUCT_LOW_BYTE(PRODUCT_LOW_BYTE));
`default_nettype wire

/* File: bench/tb_top.sv */
// Bench: queued expectations checked on each done pulse.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    reg clk = 0, rst = 1, vld = 0, ext = 0;
    reg [15:0] ins = 0, pm = 0;
    reg [7:0] acc = 0, k, a, x, y, f;
    reg [3:0] bank_select_reg = 0;
    reg [4:0] fm = 0;
    reg [11:0] base = 0, dad = 0, ad;
    reg [21:0] q[$];
    reg [21:0] e;
    reg ab, sb = 0;
    reg [31:0] rs = 32'h1a34;
    wire rdy, done, bad;
    wire [2:0] phs;
    wire [7:0] ph, pl, dd;
    wire [4:0] sf;
    int miscompares = 0, checked = 0;
    always #10 clk = ~clk;
    mne_exec i_mne_exec (.SYS_CLK(clk), .RESET(rst), .INSTR(ins),
        .INSTR_VALID(vld), .INSTR_READY(rdy), .INSTR_DONE(done),
        .ACCUM(acc), .BANK_SELECT_REG(bank_select_reg), .INDEX_BASE(base),
        .EXT_SET_EN(ext), .PRODUCT_HIGH_BYTE(ph), .PRODUCT_LOW_BYTE(pl),
        .STATUS_FLAGS(sf), .PHASE(phs), .BAD_OPCODE(bad), .DBG_ADDR(dad),
        .DBG_DATA(dd));
    function automatic [31:0] xs(input [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        xs = s ^ (s << 5);
    endfunction
    task chk(input string n, input [20:0] ex, g);
        checked++;
        // Unknowns never count as a match
        miscompares += (g !== ex || $isunknown({ex, g}));
        if (g !== ex || $isunknown({ex, g}))
            $display("MISMATCH %s exp %h got %h", n, ex, g);
    endtask
    task close_out(input int extra);
        miscompares += extra;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task idle;
        while (rdy !== 1'b1)
            @(negedge clk);
    endtask
    // Accumulator held until the next take, as the process phase reads it
    task issue(input [15:0] w, p, input [7:0] av, input [4:0] fl,
        input bx);
        idle();
        ins = w;
        acc = av;
        vld = 1;
        @(posedge clk);
        q.push_back({bx, p, fl});
        pm = p;
        fm = fl;
        @(negedge clk);
        vld = 0;
    endtask
    always @(posedge clk)
    begin
        if (bad === 1'b1)
            sb = 1'b1;
        if (done === 1'b1)
        begin
            e = q.pop_front();
            chk("result", e[20:0], {ph, pl, sf});
            chk("bad opcode", e[21], sb);
            chk("phase", 21'h7, phs);
            sb = 1'b0;
        end
    end
    initial #200000 close_out(1);
    initial
    begin
        // Data memory has no reset; seed it so negates see known bytes
        for (int j = 0; j < 4096; j++)
        begin
            rs = xs(rs);
            i_mne_exec.u_ram.mem[j] = rs[7:0];
        end
        repeat (8) @(negedge clk);
        rst = 0;
        for (int i = 0; i < 12; i++)
        begin
            rs = xs(rs);
            a = i ? rs[15:8] : 8'he2;
            k = i ? rs[7:0] : 8'hc4;
            issue({8'h0d, k}, {8'h0, a} * k, a, fm, 1'b0);
            issue(i[0] ? {4'hf, rs[27:16]} : 16'h0, pm, k, fm, 1'b0);
            idle();
            rs = xs(rs);
            // First four passes pin the indexed and access-bank edges
            ext = i < 4 ? i < 2 : rs[1];
            ab = i < 4 ? 1'b0 : rs[0];
            bank_select_reg = rs[5:2];
            base = rs[17:6];
            f = i < 4 ? 8'h5f + i[0] : rs[25:18];
            ad = ab ? {bank_select_reg, f} : ext && f <= 8'h5f ? base + f
                : {f < 8'h60 ? 4'h0 : 4'hf, f};
            dad = ad;
            @(negedge clk);
            x = dd;
            y = ~x + 8'h1;
            issue({7'h36, ab, f}, pm, a,
                {y[7], x == 8'h80, y == 8'h0, x[3:0] == 4'h0, x == 8'h0},
                1'b0);
            issue({7'h01, ab, f}, {8'h0, a} * y, a, fm, 1'b0);
            // Words outside the set run as no-ops and are flagged
            issue({i[0] ? 8'h0e : 8'h5a, k}, pm, a, fm, 1'b1);
        end
        while (q.size() != 0)
            @(negedge clk);
        close_out(0);
    end
endmodule // tb_top
`default_nettype wire
